// *** logic/mbbid_decode.sv ***
`timescale 1ns/1ns
`include "mbbid_defs.svh"
module mbbid_decode import mbbid_pkg::*; (
  input wire logic [7:0] opcode,
  output mbbid_class_t op_class,
  output logic [1:0] op_len,
  output logic [2:0] cyc_not_taken,
  output logic [2:0] cyc_taken
);
  mbbid_dec_t dec;

  always_comb begin
    casez (opcode)
      `MBBID_OP_IDLE, `MBBID_OP_SPARE: dec = '{MBBID_CLS_IDLE, `MBBID_LEN_1, `MBBID_CYC_1, `MBBID_CYC_1};
      `MBBID_OP_CLEAR_C, `MBBID_OP_SET_C, `MBBID_OP_INVERT_C:
        dec = '{MBBID_CLS_BOOL_C, `MBBID_LEN_1, `MBBID_CYC_1, `MBBID_CYC_1};
      `MBBID_OP_CLEAR_BIT, `MBBID_OP_SET_BIT, `MBBID_OP_INVERT_BIT, `MBBID_OP_AND_BIT, `MBBID_OP_AND_NBIT,
      `MBBID_OP_OR_BIT, `MBBID_OP_OR_NBIT:
        dec = '{MBBID_CLS_BOOL_BIT, `MBBID_LEN_2, `MBBID_CYC_2, `MBBID_CYC_2};
      `MBBID_OP_BIT_TO_C, `MBBID_OP_C_TO_BIT:
        dec = '{MBBID_CLS_BOOL_BIT, `MBBID_LEN_2, `MBBID_CYC_2, `MBBID_CYC_2};
      `MBBID_OP_BR_CARRY, `MBBID_OP_BR_NO_CARRY:
        dec = '{MBBID_CLS_BR_CARRY, `MBBID_LEN_2, `MBBID_CYC_2, `MBBID_CYC_3};
      `MBBID_OP_BR_BIT_SET, `MBBID_OP_BR_BIT_CLEAR, `MBBID_OP_BR_CLEAR_BIT:
        dec = '{MBBID_CLS_BR_BIT, `MBBID_LEN_3, `MBBID_CYC_3, `MBBID_CYC_4};
      `MBBID_OP_SHORT_CALL: dec = '{MBBID_CLS_SHORT_CALL, `MBBID_LEN_2, `MBBID_CYC_3, `MBBID_CYC_3};
      `MBBID_OP_PAGE_JUMP: dec = '{MBBID_CLS_PAGE_JUMP, `MBBID_LEN_2, `MBBID_CYC_3, `MBBID_CYC_3};
      `MBBID_OP_LONG_CALL: dec = '{MBBID_CLS_LONG_CALL, `MBBID_LEN_3, `MBBID_CYC_4, `MBBID_CYC_4};
      `MBBID_OP_LONG_JUMP: dec = '{MBBID_CLS_LONG_JUMP, `MBBID_LEN_3, `MBBID_CYC_4, `MBBID_CYC_4};
      `MBBID_OP_SUB_EXIT, `MBBID_OP_INT_EXIT:
        dec = '{MBBID_CLS_EXIT, `MBBID_LEN_1, `MBBID_CYC_5, `MBBID_CYC_5};
      `MBBID_OP_REL_JUMP: dec = '{MBBID_CLS_REL_JUMP, `MBBID_LEN_2, `MBBID_CYC_3, `MBBID_CYC_3};
      `MBBID_OP_TABLE_JUMP: dec = '{MBBID_CLS_TABLE_JUMP, `MBBID_LEN_1, `MBBID_CYC_3, `MBBID_CYC_3};
      `MBBID_OP_BR_ACC_ZERO, `MBBID_OP_BR_ACC_NZ:
        dec = '{MBBID_CLS_BR_ACC, `MBBID_LEN_2, `MBBID_CYC_2, `MBBID_CYC_3};
      `MBBID_OP_CMP_DIRECT, `MBBID_OP_CMP_PTR_IMM:
        dec = '{MBBID_CLS_CMP_LONG, `MBBID_LEN_3, `MBBID_CYC_4, `MBBID_CYC_5};
      `MBBID_OP_CMP_ACC_IMM, `MBBID_OP_CMP_REG_IMM:
        dec = '{MBBID_CLS_CMP_SHORT, `MBBID_LEN_3, `MBBID_CYC_3, `MBBID_CYC_4};
      `MBBID_OP_DEC_REG: dec = '{MBBID_CLS_DEC_REG, `MBBID_LEN_2, `MBBID_CYC_2, `MBBID_CYC_3};
      `MBBID_OP_DEC_DIRECT: dec = '{MBBID_CLS_DEC_DIRECT, `MBBID_LEN_3, `MBBID_CYC_3, `MBBID_CYC_4};
      default: dec = '{MBBID_CLS_UNKNOWN, `MBBID_LEN_1, `MBBID_CYC_1, `MBBID_CYC_1};
    endcase
  end

  assign op_class = dec.cls;
  assign op_len = dec.len;
  assign cyc_not_taken = dec.cyc_nt;
  assign cyc_taken = dec.cyc_t;
endmodule : mbbid_decode

// *** logic/mbbid_defs.svh ***
`ifndef MBBID_DEFS_SVH
`define MBBID_DEFS_SVH
// Register byte offsets
`define MBBID_OFF_CTRL 8'h00
`define MBBID_OFF_INSTR 8'h04
`define MBBID_OFF_PC 8'h08
`define MBBID_OFF_STATUS_WORD 8'h0c
`define MBBID_OFF_OPERAND 8'h10
`define MBBID_OFF_POINTERS 8'h14
`define MBBID_OFF_RESULT 8'h18
`define MBBID_OFF_STATUS 8'h1c
// Field positions
`define MBBID_CTRL_START 0
`define MBBID_SW_CARRY 7
`define MBBID_SW_BANK_HI 4
`define MBBID_SW_BANK_LO 3
`define MBBID_SW_PARITY 0
`define MBBID_STAT_DONE 1
`define MBBID_DIRECT_SPECIAL 7
// Reset values and fixed constants
`define MBBID_RST_STATUS_WORD 8'h00
`define MBBID_ZERO_BYTE 8'h00
`define MBBID_ONE_BYTE 8'h01
`define MBBID_BIT_AREA_BASE 8'h20
`define MBBID_CODE_SIZE 16'h1e00
// Opcodes
`define MBBID_OP_IDLE 8'h00
`define MBBID_OP_SPARE 8'ha5
`define MBBID_OP_CLEAR_C 8'hc3
`define MBBID_OP_SET_C 8'hd3
`define MBBID_OP_INVERT_C 8'hb3
`define MBBID_OP_CLEAR_BIT 8'hc2
`define MBBID_OP_SET_BIT 8'hd2
`define MBBID_OP_INVERT_BIT 8'hb2
`define MBBID_OP_AND_BIT 8'h82
`define MBBID_OP_AND_NBIT 8'hb0
`define MBBID_OP_OR_BIT 8'h72
`define MBBID_OP_OR_NBIT 8'ha0
`define MBBID_OP_BIT_TO_C 8'ha2
`define MBBID_OP_C_TO_BIT 8'h92
`define MBBID_OP_BR_CARRY 8'h40
`define MBBID_OP_BR_NO_CARRY 8'h50
`define MBBID_OP_BR_BIT_SET 8'h20
`define MBBID_OP_BR_BIT_CLEAR 8'h30
`define MBBID_OP_BR_CLEAR_BIT 8'h10
`define MBBID_OP_SHORT_CALL 8'b???10001
`define MBBID_OP_PAGE_JUMP 8'b???00001
`define MBBID_OP_LONG_CALL 8'h12
`define MBBID_OP_LONG_JUMP 8'h02
`define MBBID_OP_SUB_EXIT 8'h22
`define MBBID_OP_INT_EXIT 8'h32
`define MBBID_OP_REL_JUMP 8'h80
`define MBBID_OP_TABLE_JUMP 8'h73
`define MBBID_OP_BR_ACC_ZERO 8'h60
`define MBBID_OP_BR_ACC_NZ 8'h70
`define MBBID_OP_CMP_DIRECT 8'hb5
`define MBBID_OP_CMP_ACC_IMM 8'hb4
`define MBBID_OP_CMP_PTR_IMM 8'b1011011?
`define MBBID_OP_CMP_REG_IMM 8'b10111???
`define MBBID_OP_DEC_REG 8'b11011???
`define MBBID_OP_DEC_DIRECT 8'hd5
// Lengths and cycle counts
`define MBBID_LEN_1 2'h1
`define MBBID_LEN_2 2'h2
`define MBBID_LEN_3 2'h3
`define MBBID_CYC_1 3'h1
`define MBBID_CYC_2 3'h2
`define MBBID_CYC_3 3'h3
`define MBBID_CYC_4 3'h4
`define MBBID_CYC_5 3'h5
`endif

// *** logic/mbbid_pkg.sv ***
package mbbid_pkg;
  typedef enum logic [1:0] {
    MBBID_ST_IDLE = 2'b01,
    MBBID_ST_EXEC = 2'b10
  } mbbid_state_t;

  typedef enum logic [4:0] {
    MBBID_CLS_UNKNOWN, MBBID_CLS_IDLE, MBBID_CLS_BOOL_C, MBBID_CLS_BOOL_BIT,
    MBBID_CLS_BR_CARRY, MBBID_CLS_BR_BIT, MBBID_CLS_BR_ACC, MBBID_CLS_CMP_LONG,
    MBBID_CLS_CMP_SHORT, MBBID_CLS_DEC_REG, MBBID_CLS_DEC_DIRECT, MBBID_CLS_REL_JUMP,
    MBBID_CLS_PAGE_JUMP, MBBID_CLS_SHORT_CALL, MBBID_CLS_LONG_JUMP, MBBID_CLS_LONG_CALL,
    MBBID_CLS_EXIT, MBBID_CLS_TABLE_JUMP
  } mbbid_class_t;

  typedef struct packed {
    mbbid_class_t cls;
    logic [1:0] len;
    logic [2:0] cyc_nt;
    logic [2:0] cyc_t;
  } mbbid_dec_t;
endpackage : mbbid_pkg

// *** logic/mbbid_top.sv ***
`timescale 1ns/1ns
`include "mbbid_defs.svh"
module mbbid_top import mbbid_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef struct packed {
    mbbid_state_t state;
    logic [2:0] cnt;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [23:0] instr;
    logic [15:0] pc;
    logic [7:0] status_word;
    logic [7:0] acc;
    logic [7:0] opnd;
    logic bit_in;
    logic [15:0] data_ptr;
    logic [15:0] ret_addr;
    logic [15:0] target;
    logic [7:0] wr_byte;
    logic [7:0] loc;
    logic carry_new;
    logic done;
    logic taken;
    logic unknown;
    logic range_err;
    logic bit_we;
    logic bit_val;
    logic byte_we;
    logic push;
    logic pop;
    logic special;
    logic [2:0] bit_sel;
    logic [1:0] len;
    logic [2:0] cycles;
  } mbbid_regs_t;

  localparam mbbid_regs_t MBBID_RST = '{state: MBBID_ST_IDLE, status_word: `MBBID_RST_STATUS_WORD, default: '0};

  mbbid_regs_t r_q;
  mbbid_regs_t r_d;

  mbbid_class_t dec_class;
  logic [1:0] dec_len;
  logic [2:0] dec_nt;
  logic [2:0] dec_t;
  logic [7:0] op;
  logic [7:0] b1;
  logic [7:0] b2;
  logic carry;
  logic [15:0] seq_pc;
  logic x_take;
  logic x_carry;
  logic [15:0] x_target;
  logic x_bit_we;
  logic x_bit_val;
  logic x_byte_we;
  logic [7:0] x_byte;
  logic [7:0] x_loc;
  logic x_push;
  logic x_pop;
  logic [7:0] cmp_a;
  logic [7:0] cmp_b;
  logic x_range;
  logic [2:0] x_cycles;
  logic [31:0] rd_val;

  function automatic logic [15:0] rel_target(input logic [15:0] base, input logic [7:0] rel);
    rel_target = base + {{8{rel[7]}}, rel};
  endfunction : rel_target

  function automatic logic [7:0] bank_addr(input logic [7:0] sw, input logic [2:0] idx);
    bank_addr = {3'h0, sw[`MBBID_SW_BANK_HI], sw[`MBBID_SW_BANK_LO], idx};
  endfunction : bank_addr

  function automatic logic [7:0] bit_byte(input logic [7:0] bit_addr);
    if (bit_addr[`MBBID_DIRECT_SPECIAL]) begin
      bit_byte = {bit_addr[7:3], 3'h0};
    end else begin
      bit_byte = `MBBID_BIT_AREA_BASE + {4'h0, bit_addr[6:3]};
    end
  endfunction : bit_byte

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `MBBID_OFF_CTRL) || (a == `MBBID_OFF_INSTR) || (a == `MBBID_OFF_PC) ||
              (a == `MBBID_OFF_STATUS_WORD) || (a == `MBBID_OFF_OPERAND) || (a == `MBBID_OFF_POINTERS) ||
              (a == `MBBID_OFF_RESULT) || (a == `MBBID_OFF_STATUS);
  endfunction : addr_ok

  mbbid_decode u_decode (
    .opcode(op),
    .op_class(dec_class),
    .op_len(dec_len),
    .cyc_not_taken(dec_nt),
    .cyc_taken(dec_t)
  );

  assign op = r_q.instr[7:0];
  assign b1 = r_q.instr[15:8];
  assign b2 = r_q.instr[23:16];
  assign carry = r_q.status_word[`MBBID_SW_CARRY];
  assign seq_pc = r_q.pc + {14'h0, dec_len};

  // Operand fetch for compare forms
  always_comb begin
    cmp_a = r_q.opnd;
    cmp_b = b1;
    if (op == `MBBID_OP_CMP_DIRECT) begin
      cmp_a = r_q.acc;
      cmp_b = r_q.opnd;
    end else if (op == `MBBID_OP_CMP_ACC_IMM) begin
      cmp_a = r_q.acc;
    end
  end

  // Evaluation of the pending instruction
  always_comb begin
    x_take = 1'b0;
    x_carry = carry;
    x_target = seq_pc;
    x_bit_we = 1'b0;
    x_bit_val = 1'b0;
    x_byte_we = 1'b0;
    x_byte = `MBBID_ZERO_BYTE;
    x_loc = `MBBID_ZERO_BYTE;
    x_push = 1'b0;
    x_pop = 1'b0;
    case (dec_class)
      MBBID_CLS_BOOL_C: begin
        if (op == `MBBID_OP_CLEAR_C) begin
          x_carry = 1'b0;
        end else if (op == `MBBID_OP_SET_C) begin
          x_carry = 1'b1;
        end else begin
          x_carry = ~carry;
        end
      end
      MBBID_CLS_BOOL_BIT: begin
        x_loc = bit_byte(b1);
        case (op)
          `MBBID_OP_CLEAR_BIT: begin
            x_bit_we = 1'b1;
          end
          `MBBID_OP_SET_BIT: begin
            x_bit_we = 1'b1;
            x_bit_val = 1'b1;
          end
          `MBBID_OP_INVERT_BIT: begin
            x_bit_we = 1'b1;
            x_bit_val = ~r_q.bit_in;
          end
          `MBBID_OP_AND_BIT: x_carry = carry & r_q.bit_in;
          `MBBID_OP_AND_NBIT: x_carry = carry & ~r_q.bit_in;
          `MBBID_OP_OR_BIT: x_carry = carry | r_q.bit_in;
          `MBBID_OP_OR_NBIT: x_carry = carry | ~r_q.bit_in;
          `MBBID_OP_BIT_TO_C: x_carry = r_q.bit_in;
          default: begin
            x_bit_we = 1'b1;
            x_bit_val = carry;
          end
        endcase
      end
      MBBID_CLS_BR_CARRY: begin
        x_take = (op == `MBBID_OP_BR_NO_CARRY) ? ~carry : carry;
        if (x_take) begin
          x_target = rel_target(seq_pc, b1);
        end
      end
      MBBID_CLS_BR_BIT: begin
        x_loc = bit_byte(b1);
        x_take = (op == `MBBID_OP_BR_BIT_CLEAR) ? ~r_q.bit_in : r_q.bit_in;
        if (op == `MBBID_OP_BR_CLEAR_BIT && r_q.bit_in) begin
          x_bit_we = 1'b1;
        end
        if (x_take) begin
          x_target = rel_target(seq_pc, b2);
        end
      end
      MBBID_CLS_BR_ACC: begin
        x_take = (r_q.acc == `MBBID_ZERO_BYTE) ^ (op == `MBBID_OP_BR_ACC_NZ);
        if (x_take) begin
          x_target = rel_target(seq_pc, b1);
        end
      end
      MBBID_CLS_CMP_LONG, MBBID_CLS_CMP_SHORT: begin
        if (op == `MBBID_OP_CMP_DIRECT) begin
          x_loc = b1;
        end else if (op != `MBBID_OP_CMP_ACC_IMM) begin
          x_loc = (dec_class == MBBID_CLS_CMP_LONG) ? bank_addr(r_q.status_word, {2'h0, op[0]}) :
                  bank_addr(r_q.status_word, op[2:0]);
        end
        x_take = cmp_a != cmp_b;
        x_carry = cmp_a < cmp_b;
        if (x_take) begin
          x_target = rel_target(seq_pc, b2);
        end
      end
      MBBID_CLS_DEC_REG, MBBID_CLS_DEC_DIRECT: begin
        x_loc = (dec_class == MBBID_CLS_DEC_REG) ? bank_addr(r_q.status_word, op[2:0]) : b1;
        x_byte_we = 1'b1;
        x_byte = r_q.opnd - `MBBID_ONE_BYTE;
        x_take = x_byte != `MBBID_ZERO_BYTE;
        if (x_take) begin
          x_target = rel_target(seq_pc, (dec_class == MBBID_CLS_DEC_REG) ? b1 : b2);
        end
      end
      MBBID_CLS_REL_JUMP: begin
        x_take = 1'b1;
        x_target = rel_target(seq_pc, b1);
      end
      MBBID_CLS_PAGE_JUMP, MBBID_CLS_SHORT_CALL: begin
        x_take = 1'b1;
        x_push = dec_class == MBBID_CLS_SHORT_CALL;
        x_target = {seq_pc[15:11], op[7:5], b1};
      end
      MBBID_CLS_LONG_JUMP, MBBID_CLS_LONG_CALL: begin
        x_take = 1'b1;
        x_push = dec_class == MBBID_CLS_LONG_CALL;
        x_target = {b1, b2};
      end
      MBBID_CLS_EXIT: begin
        x_take = 1'b1;
        x_pop = 1'b1;
        x_target = r_q.ret_addr;
      end
      MBBID_CLS_TABLE_JUMP: begin
        x_take = 1'b1;
        x_target = r_q.data_ptr + {8'h00, r_q.acc};
      end
      default: x_take = 1'b0;
    endcase
  end

  assign x_range = (dec_class == MBBID_CLS_LONG_JUMP || dec_class == MBBID_CLS_LONG_CALL) &&
                   (x_target >= `MBBID_CODE_SIZE);
  assign x_cycles = x_take ? dec_t : dec_nt;

  // Register read mux
  always_comb begin
    rd_val = 32'h0000_0000;
    case (paddr)
      `MBBID_OFF_INSTR: rd_val = {8'h00, r_q.instr};
      `MBBID_OFF_PC: rd_val = {16'h0000, r_q.pc};
      `MBBID_OFF_STATUS_WORD: rd_val = {24'h00_0000, r_q.status_word};
      `MBBID_OFF_OPERAND: rd_val = {15'h0000, r_q.bit_in, r_q.opnd, r_q.acc};
      `MBBID_OFF_POINTERS: rd_val = {r_q.ret_addr, r_q.data_ptr};
      `MBBID_OFF_RESULT: rd_val = {r_q.loc, r_q.wr_byte, r_q.target};
      `MBBID_OFF_STATUS: rd_val = {9'h000, r_q.cycles, 2'h0, r_q.len, 1'b0, r_q.bit_sel, 1'b0, r_q.special,
                                   r_q.pop, r_q.push, r_q.byte_we, r_q.bit_val, r_q.bit_we, r_q.range_err,
                                   r_q.unknown, r_q.taken, r_q.done, r_q.state == MBBID_ST_EXEC};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Next-state logic
  always_comb begin
    logic go;
    go = 1'b0;
    r_d = r_q;
    r_d.pready = 1'b0;
    r_d.pslverr = 1'b0;
    if (psel && !penable) begin
      r_d.pready = 1'b1;
      r_d.pslverr = !addr_ok(paddr);
      r_d.prdata = (pwrite || !addr_ok(paddr)) ? 32'h0000_0000 : rd_val;
    end
    if (psel && penable && r_q.pready && pwrite) begin
      case (paddr)
        `MBBID_OFF_CTRL: go = pwdata[`MBBID_CTRL_START];
        `MBBID_OFF_INSTR: r_d.instr = pwdata[23:0];
        `MBBID_OFF_PC: r_d.pc = pwdata[15:0];
        `MBBID_OFF_STATUS_WORD: r_d.status_word[7:1] = pwdata[7:1];
        `MBBID_OFF_OPERAND: begin
          r_d.acc = pwdata[7:0];
          r_d.opnd = pwdata[15:8];
          r_d.bit_in = pwdata[16];
        end
        `MBBID_OFF_POINTERS: begin
          r_d.data_ptr = pwdata[15:0];
          r_d.ret_addr = pwdata[31:16];
        end
        `MBBID_OFF_STATUS: begin
          if (pwdata[`MBBID_STAT_DONE]) begin
            r_d.done = 1'b0;
          end
        end
        default: go = 1'b0;
      endcase
    end
    unique case (r_q.state)
      MBBID_ST_IDLE: begin
        if (go) begin
          r_d.state = MBBID_ST_EXEC;
          r_d.cnt = x_cycles - `MBBID_CYC_1;
          r_d.done = 1'b0;
          r_d.taken = x_take;
          r_d.carry_new = x_carry;
          r_d.target = x_target;
          r_d.wr_byte = x_byte;
          r_d.loc = x_loc;
          r_d.special = x_loc[`MBBID_DIRECT_SPECIAL];
          r_d.bit_sel = b1[2:0];
          r_d.bit_we = x_bit_we;
          r_d.bit_val = x_bit_val;
          r_d.byte_we = x_byte_we;
          r_d.push = x_push;
          r_d.pop = x_pop;
          r_d.unknown = dec_class == MBBID_CLS_UNKNOWN;
          r_d.range_err = x_range;
          r_d.len = dec_len;
          r_d.cycles = x_cycles;
        end
      end
      MBBID_ST_EXEC: begin
        if (r_q.cnt == 3'h0) begin
          r_d.state = MBBID_ST_IDLE;
          r_d.done = 1'b1;
          r_d.status_word[`MBBID_SW_CARRY] = r_q.carry_new;
        end else begin
          r_d.cnt = r_q.cnt - 3'h1;
        end
      end
    endcase
    r_d.status_word[`MBBID_SW_PARITY] = ^r_d.acc;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_q <= MBBID_RST;
    end else begin
      r_q <= r_d;
    end
  end

  assign prdata = r_q.prdata;
  assign pready = r_q.pready;
  assign pslverr = r_q.pslverr;
endmodule : mbbid_top

// *** testbench/mbbid_properties.sv ***
`timescale 1ns/1ns
`include "mbbid_defs.svh"
module mbbid_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence rd_setup_s(logic [7:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  property len_cyc_p;
    rd_setup_s(`MBBID_OFF_STATUS) |=> !prdata[1] || {prdata[22:20], prdata[17:16]} inside
      {5'h05, 5'h0d, 5'h15, 5'h0a, 5'h0e, 5'h0f, 5'h13, 5'h17};
  endproperty
  ready_after_setup_a: assert property (setup_s |=> pready) else $error("no ready after setup");
  ready_single_a: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  ready_access_a: assert property (pready |-> psel && penable) else $error("ready outside access");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  unmapped_err_a: assert property (setup_s ##0 paddr > 8'h1c |=> pslverr) else $error("unmapped not refused");
  mapped_ok_a: assert property (setup_s ##0 (paddr <= 8'h1c && paddr[1:0] == 2'h0) |=> !pslverr)
    else $error("mapped address refused");
  rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("read data moved");
  ctrl_read_zero_a: assert property (rd_setup_s(`MBBID_OFF_CTRL) |=> prdata == 32'h0)
    else $error("control read not zero");
  unmapped_zero_a: assert property (setup_s ##0 (!pwrite && paddr > 8'h1c) |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  len_cycles_a: assert property (len_cyc_p) else $error("length and cycles disagree");
endmodule : mbbid_properties

bind mbbid_top mbbid_properties u_props (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr);

// *** testbench/tb.sv ***
`timescale 1ns/1ns
`include "mbbid_defs.svh"
module tb import mbbid_pkg::*;;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, r1, r2;
  int err_total, compares, cyc_n, seed, p, i;

  mbbid_top dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task print_verdict;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task bad(input string m);
    $display("BAD %0t %s", $time, m);
    err_total++;
  endtask : bad

  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 40000) begin
      bad("timeout");
      print_verdict();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) bad($sformatf("got %h expected %h", got, exp));
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) bad("no ready");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic bool_c(input logic [7:0] op, input logic c, t);
    case (op)
      8'h82: return c & t;
      8'hb0: return c & ~t;
      8'h72: return c | t;
      8'ha0: return c | ~t;
      8'ha2: return t;
      default: return c;
    endcase
  endfunction : bool_c

  task run(input logic [7:0] op, b1, b2, acc, opv, input logic t, c, input logic [1:0] bk,
    input logic [15:0] pc, ra, dp);
    logic [1:0] len;
    logic [2:0] cnt;
    logic [7:0] off, x, y, loc;
    logic [15:0] tgt, p2;
    logic cnd, tk, nc, unk, lc;
    logic [4:0] fl;
    logic [31:0] res, st;
    int n;
    {off, x, y, nc, len, cnt} = {b1, acc, b1, c, 2'h1, 3'h1};
    {cnd, tk, unk, lc} = 4'h0;
    p2 = pc + 16'h2;
    loc = b1[7] ? {b1[7:3], 3'h0} : 8'h20 + {4'h0, b1[6:3]};
    case (op) inside
      8'hc3, 8'hd3, 8'hb3: nc = (op == 8'hc3) ? 1'b0 : (op == 8'hd3) | ~c;
      8'hc2, 8'hd2, 8'hb2, 8'h92, 8'h82, 8'hb0, 8'h72, 8'ha0, 8'ha2: begin
        {len, cnt, lc} = {2'h2, 3'h2, 1'b1};
        nc = bool_c(op, c, t);
      end
      8'h40, 8'h50, 8'h60, 8'h70, 8'h80: begin
        {len, cnt, cnd} = {2'h2, 3'h2, 1'b1};
        tk = op == 8'h40 ? c : op == 8'h50 ? ~c : op == 8'h60 ? acc == 8'h0 : op != 8'h70 || acc != 8'h0;
      end
      8'h20, 8'h30, 8'h10: begin
        {len, cnt, cnd, lc, off} = {2'h3, 3'h3, 2'h3, b2};
        tk = (op == 8'h30) ^ t;
      end
      8'b????0001: {len, cnt, tgt} = {2'h2, 3'h3, p2[15:11], op[7:5], b1};
      8'h02, 8'h12: {len, cnt, tgt} = {2'h3, 3'h4, b1, b2};
      8'h22, 8'h32: {cnt, tgt} = {3'h5, ra};
      8'h73: {cnt, tgt} = {3'h3, dp + {8'h0, acc}};
      8'hb5, 8'hb6, 8'hb7: {len, cnt, cnd, off} = {2'h3, 3'h4, 1'b1, b2};
      8'hb4, 8'b10111???: {len, cnt, cnd, off} = {2'h3, 3'h3, 1'b1, b2};
      8'b11011???: {len, cnt, cnd} = {2'h2, 3'h2, 1'b1};
      8'hd5: {len, cnt, cnd, off, lc, loc} = {2'h3, 3'h3, 1'b1, b2, 1'b1, b1};
      8'h00, 8'ha5: ;
      default: unk = 1'b1;
    endcase
    if (op inside {8'hb6, 8'hb7} || op[7:3] inside {5'h17, 5'h1b}) begin
      {x, lc} = {opv, 1'b1};
      loc = op[3] ? {3'h0, bk, op[2:0]} : {3'h0, bk, 2'h0, op[0]};
    end
    if (op == 8'hb5) y = opv;
    if (op[7:4] == 4'hb && op[3:2] != 2'h0) {tk, nc} = {x != y, x < y};
    if (op == 8'hd5 || op[7:3] == 5'h1b) tk = opv != 8'h1;
    if (cnd) tgt = pc + {14'h0, len} + (tk ? {{8{off[7]}}, off} : 16'h0);
    else if (cnt < 3'h3) tgt = pc + {14'h0, len};
    fl = {op inside {8'h22, 8'h32}, op == 8'h12 || op[4:0] == 5'h11, op == 8'hd5 || op[7:3] == 5'h1b,
          op == 8'hd2 || (op == 8'hb2 && !t) || (op == 8'h92 && c),
          op inside {8'hc2, 8'hd2, 8'hb2, 8'h92} || (op == 8'h10 && t)};
    apb(1'b1, `MBBID_OFF_INSTR, {8'h0, b2, b1, op});
    apb(1'b1, `MBBID_OFF_PC, {16'h0, pc});
    apb(1'b1, `MBBID_OFF_OPERAND, {15'h0, t, opv, acc});
    apb(1'b1, `MBBID_OFF_POINTERS, {ra, dp});
    apb(1'b1, `MBBID_OFF_STATUS_WORD, {24'h0, c, 2'h0, bk, 3'h0});
    apb(1'b1, `MBBID_OFF_CTRL, 32'h1);
    {n, rd} = {32'h0, 32'h0};
    while (rd[1] !== 1'b1 && n < 20) begin
      apb(1'b0, `MBBID_OFF_STATUS, 32'h0);
      n++;
    end
    if (n >= 20) bad("no done");
    st = rd;
    apb(1'b0, `MBBID_OFF_RESULT, 32'h0);
    res = rd;
    chk({st[22:20], st[17:16]}, {cnt + {2'h0, tk}, len});
    chk(st[3], unk);
    if (!unk) chk(res[15:0], tgt);
    if (lc) chk({st[10], res[31:24]}, {loc[7], loc});
    if (op == 8'hd5 || op[7:3] == 5'h1b) chk(res[23:16], opv - 8'h1);
    if (op == 8'h10) chk(st[6:5], {1'b0, t});
    chk(st[9:5], fl);
    if (op inside {8'h02, 8'h12}) chk(st[4], tgt >= `MBBID_CODE_SIZE);
    apb(1'b0, `MBBID_OFF_STATUS_WORD, 32'h0);
    chk({rd[7], rd[4:3], rd[0]}, {nc, bk, ^acc});
  endtask : run

  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 8'h0, 32'h0};
    {err_total, compares, cyc_n, seed} = {32'h0, 32'h0, 32'h0, 32'h815a};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `MBBID_OFF_STATUS_WORD, 32'h0);
    chk(rd, `MBBID_RST_STATUS_WORD);
    apb(1'b0, 8'h20, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
    apb(1'b1, 8'h24, 32'hffffffff);
    chk(er, 1'b1);
    for (p = 0; p < 2; p++) begin
      for (i = 0; i < 256; i++) begin
        r1 = $random(seed);
        r2 = $random(seed);
        if (p == 1) {r1, r2[3:0]} = {8'h1, 8'h0, 8'h7f, 8'h80, 4'hf};
        run(i[7:0], r1[7:0], r1[15:8], r1[23:16], r1[31:24], r2[0], r2[1], r2[3:2],
          p == 1 ? 16'hfffe : r2[19:4], r2[31:16], p == 1 ? 16'hffff : r2[15:0]);
      end
    end
    apb(1'b1, `MBBID_OFF_STATUS, 32'h2);
    apb(1'b0, `MBBID_OFF_STATUS, 32'h0);
    chk(rd[1], 1'b0);
    print_verdict();
  end
endmodule : tb
